//--- qdc_pkg.sv
/*
 * constants and types shared by the quad converter serial command logic:
 * word layout, command and channel codes, power-up delay counts, states.
 * assumes a 25 MHz system clock; the serial clock belongs to the host.
 */
`default_nettype none

package qdc_pkg;

	// word layout, last 24 bits of the shift register
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int DATA_LSB = 0;
	localparam int DATA_BITS = 16;
	localparam int WORD_MIN_BITS = 24;
	localparam int WORD_MAX_BITS = 32;
	localparam int NUM_CHANNELS = 4;
	localparam int COUNT_W = 6;
	localparam logic [COUNT_W-1:0] COUNT_SAT = 6'h20;
	localparam logic [COUNT_W-1:0] COUNT_MIN = 6'h18;

	// command codes
	localparam logic [3:0] CMD_WRITE = 4'h0;
	localparam logic [3:0] CMD_UPDATE = 4'h1;
	localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
	localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
	localparam logic [3:0] CMD_NOP = 4'hF;

	// channel select codes
	localparam logic [3:0] ADDR_CH0 = 4'h0;
	localparam logic [3:0] ADDR_CH1 = 4'h1;
	localparam logic [3:0] ADDR_CH2 = 4'h2;
	localparam logic [3:0] ADDR_CH3 = 4'h3;
	localparam logic [3:0] ADDR_ALL = 4'hF;

	// power-up delays, in ns, and their cycle counts (least times, rounded up)
	localparam int CLK_PERIOD_NS = 40;
	localparam int PU_SHORT_NS = 5000;
	localparam int PU_BIAS_HI_NS = 12000;
	localparam int PU_BIAS_LO_NS = 30000;
	localparam int PU_W = 10;
	localparam logic [PU_W-1:0] PU_SHORT_CYC =
		PU_W'((PU_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PU_W-1:0] PU_BIAS_HI_CYC =
		PU_W'((PU_BIAS_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PU_W-1:0] PU_BIAS_LO_CYC =
		PU_W'((PU_BIAS_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// command execution sequence in the system clock domain
	typedef enum logic [1:0] {
		EX_IDLE,
		EX_LATCH,
		EX_RUN
	} qdc_exec_state_type;

	// decoded operation
	typedef enum logic [2:0] {
		OP_NONE,
		OP_WRITE,
		OP_UPDATE,
		OP_WRITE_UPD_ALL,
		OP_WRITE_UPD,
		OP_POWER_DOWN
	} qdc_op_type;

endpackage : qdc_pkg

`default_nettype wire

//--- qdc_sync.sv
/*
 * two-flop level synchroniser into the system clock domain.
 * assumes inputs are levels or quasi-static words that hold still
 * for several system clocks around any change of interest.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [WIDTH-1:0] async_in,
	output var logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q; // first stage, read only by the second

	// two stages; enable freezes both like the other system-clock state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (enable) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : qdc_sync

`default_nettype wire

//--- qdc_serial_shift.sv
/*
 * serial-clock domain front end: input shift register, bit counter
 * and the falling-edge chain output. assumes the serial clock only
 * runs around frames and that select_load_n comes from the same host.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_serial_shift
	import qdc_pkg::*;
(
	input wire logic serial_clock,
	input wire logic rst_n,
	input wire logic select_load_n,
	input wire logic serial_in,
	output var logic [WORD_MAX_BITS-1:0] shift_word,
	output var logic word_ok,
	output var logic chain_serial_out
);

	logic [COUNT_W-1:0] count_q; // bits in this frame, saturating
	logic frame_rst_n; // counter held clear while deselected

	assign frame_rst_n = rst_n & ~select_load_n;

	// shift one bit per rising edge, only while selected
	always_ff @(posedge serial_clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_word <= '0;
		end else if (!select_load_n) begin
			shift_word <= {shift_word[WORD_MAX_BITS-2:0], serial_in};
		end
	end

	// frame length; the frame's own select ends the count
	always_ff @(posedge serial_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			count_q <= '0;
		end else if (count_q != COUNT_SAT) begin
			count_q <= count_q + 6'h01;
		end
	end

	// length verdict survives deselect so the other domain can read it
	always_ff @(posedge serial_clock or negedge rst_n) begin
		if (!rst_n) begin
			word_ok <= 1'b0;
		end else if (!select_load_n) begin
			word_ok <= (count_q + 6'h01) >= COUNT_MIN;
		end
	end

	// oldest bit leaves on the falling edge after it reaches the top
	always_ff @(negedge serial_clock or negedge rst_n) begin
		if (!rst_n) begin
			chain_serial_out <= 1'b0;
		end else begin
			chain_serial_out <= shift_word[WORD_MAX_BITS-1];
		end
	end

endmodule : qdc_serial_shift

`default_nettype wire

//--- qdc_command_logic.sv
/*
 * quad converter command logic: takes serial frames from the link,
 * executes write, update and power-down commands on four channels,
 * keeps input and active code registers, power-down state and the
 * power-up settling timers. assumes a free-running 25 MHz clock and
 * a host that drives select, serial clock and data as a frame.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_command_logic #(
	parameter int CODE_BITS = 16,
	parameter bit MIDSCALE_RESET = 1'b0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic serial_clock,
	input wire logic select_load_n,
	input wire logic serial_in,
	input wire logic async_clear_n,
	input wire logic low_supply,
	output var logic chain_serial_out,
	output var logic [qdc_pkg::NUM_CHANNELS-1:0][CODE_BITS-1:0] input_code,
	output var logic [qdc_pkg::NUM_CHANNELS-1:0][CODE_BITS-1:0] dac_code,
	output var logic [qdc_pkg::NUM_CHANNELS-1:0] output_drive_en,
	output var logic [qdc_pkg::NUM_CHANNELS-1:0] channel_settled,
	output var logic bias_on,
	output var logic command_done
);
	import qdc_pkg::*;

	// code after reset or clear: zero scale, or midscale on the variant
	localparam logic [CODE_BITS-1:0] RESET_CODE =
		MIDSCALE_RESET ? {1'b1, {(CODE_BITS-1){1'b0}}} : '0;

	// combined resets
	logic code_rst_n; // power-on or clear, for the code registers
	logic link_rst_n; // serial side, also emptied by clear

	// serial side outputs, quasi-static while deselected
	logic [WORD_MAX_BITS-1:0] link_word;
	logic link_word_ok;

	// synchronised copies
	logic select_sync; // select level in the system domain
	logic [WORD_MIN_BITS:0] word_sync; // length verdict and low 24 bits
	logic low_supply_sync; // supply strap, slow level

	// execution
	qdc_exec_state_type state_q;
	qdc_exec_state_type state_d;
	logic select_prev_q; // for the rising-edge detect
	logic select_rise; // one cycle on the end of a frame
	logic [WORD_MIN_BITS-1:0] word_q; // frame taken for execution
	logic word_valid_q; // frame was at least 24 bits long

	// decoded fields of word_q
	qdc_op_type op;
	logic [3:0] addr;
	logic [CODE_BITS-1:0] new_code;
	logic [NUM_CHANNELS-1:0] sel_mask; // addressed channels
	logic [NUM_CHANNELS-1:0] write_mask; // input registers to load
	logic [NUM_CHANNELS-1:0] update_mask; // active registers to load
	logic [NUM_CHANNELS-1:0] down_mask; // channels to power down
	logic run;

	// per-channel power state
	logic [NUM_CHANNELS-1:0] power_down_q;
	logic [NUM_CHANNELS-1:0][PU_W-1:0] settle_cnt_q;

	assign code_rst_n = rst_n & async_clear_n;
	assign link_rst_n = rst_n & async_clear_n;

	// channel field to one-hot mask; reserved codes select nothing
	function automatic logic [NUM_CHANNELS-1:0] chan_mask(input logic [3:0] a);
		logic [NUM_CHANNELS-1:0] m;
		m = '0;
		case (a)
			ADDR_CH0: m = 4'h1;
			ADDR_CH1: m = 4'h2;
			ADDR_CH2: m = 4'h4;
			ADDR_CH3: m = 4'h8;
			ADDR_ALL: m = 4'hF;
			default: m = '0;
		endcase
		return m;
	endfunction : chan_mask

	// command field to operation; anything unlisted does nothing
	function automatic qdc_op_type op_of(input logic [3:0] c);
		qdc_op_type o;
		o = OP_NONE;
		case (c)
			CMD_WRITE: o = OP_WRITE;
			CMD_UPDATE: o = OP_UPDATE;
			CMD_WRITE_UPD_ALL: o = OP_WRITE_UPD_ALL;
			CMD_WRITE_UPD: o = OP_WRITE_UPD;
			CMD_POWER_DOWN: o = OP_POWER_DOWN;
			CMD_NOP: o = OP_NONE;
			default: o = OP_NONE;
		endcase
		return o;
	endfunction : op_of

	// keep the top code bits; the narrower variants drop the tail
	function automatic logic [CODE_BITS-1:0] code_of(input logic [DATA_BITS-1:0] d);
		return d[DATA_BITS-1 -: CODE_BITS];
	endfunction : code_of

	// serial front end on the link clock
	qdc_serial_shift u_shift (
		.serial_clock(serial_clock),
		.rst_n(link_rst_n),
		.select_load_n(select_load_n),
		.serial_in(serial_in),
		.shift_word(link_word),
		.word_ok(link_word_ok),
		.chain_serial_out(chain_serial_out)
	);

	// select level into the system domain
	qdc_sync #(
		.WIDTH(1)
	) u_sync_select (
		.clock(clock),
		.rst_n(rst_n),
		.enable(enable),
		.async_in(~select_load_n),
		.sync_out(select_sync)
	);

	// frame contents; they hold still from the last bit until the next frame
	qdc_sync #(
		.WIDTH(WORD_MIN_BITS + 1)
	) u_sync_word (
		.clock(clock),
		.rst_n(rst_n),
		.enable(enable),
		.async_in({link_word_ok, link_word[WORD_MIN_BITS-1:0]}),
		.sync_out(word_sync)
	);

	// supply strap picks the long bias delay
	qdc_sync #(
		.WIDTH(1)
	) u_sync_supply (
		.clock(clock),
		.rst_n(rst_n),
		.enable(enable),
		.async_in(low_supply),
		.sync_out(low_supply_sync)
	);

	// end of frame: selected level falls in the system domain
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			select_prev_q <= 1'b0;
		end else if (enable) begin
			select_prev_q <= select_sync;
		end
	end

	assign select_rise = select_prev_q & ~select_sync;

	// execution sequence: wait, take the frame, run it once
	always_comb begin
		state_d = state_q;
		case (state_q)
			EX_IDLE: begin
				if (select_rise) begin
					state_d = EX_LATCH;
				end
			end
			EX_LATCH: begin
				state_d = EX_RUN;
			end
			EX_RUN: begin
				state_d = EX_IDLE;
			end
			default: begin
				state_d = EX_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= EX_IDLE;
		end else if (enable) begin
			state_q <= state_d;
		end
	end

	// take the frame one cycle after the edge so both synchronisers agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
			word_valid_q <= 1'b0;
		end else if (enable && state_q == EX_LATCH) begin
			word_q <= word_sync[WORD_MIN_BITS-1:0];
			word_valid_q <= word_sync[WORD_MIN_BITS];
		end
	end

	// short frames are dropped whole
	assign run = (state_q == EX_RUN) && word_valid_q;

	assign op = op_of(word_q[CMD_MSB:CMD_LSB]);
	assign addr = word_q[ADDR_MSB:ADDR_LSB];
	assign new_code = code_of(word_q[DATA_MSB:DATA_LSB]);
	assign sel_mask = chan_mask(addr);

	// which registers each operation touches
	always_comb begin
		write_mask = '0;
		update_mask = '0;
		down_mask = '0;
		if (run) begin
			case (op)
				OP_WRITE: begin
					write_mask = sel_mask;
				end
				OP_UPDATE: begin
					update_mask = sel_mask;
				end
				OP_WRITE_UPD_ALL: begin
					write_mask = sel_mask;
					update_mask = '1;
				end
				OP_WRITE_UPD: begin
					write_mask = sel_mask;
					update_mask = sel_mask;
				end
				OP_POWER_DOWN: begin
					down_mask = sel_mask;
				end
				default: begin
					// no-op and reserved commands leave everything alone
					write_mask = '0;
				end
			endcase
		end
	end

	// input registers; power-down never touches them
	always_ff @(posedge clock or negedge code_rst_n) begin
		if (!code_rst_n) begin
			input_code <= {NUM_CHANNELS{RESET_CODE}};
		end else if (enable) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (write_mask[ch]) begin
					input_code[ch] <= new_code;
				end
			end
		end
	end

	// active registers; a combined write passes the new code straight through
	always_ff @(posedge clock or negedge code_rst_n) begin
		if (!code_rst_n) begin
			dac_code <= {NUM_CHANNELS{RESET_CODE}};
		end else if (enable) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (update_mask[ch]) begin
					// written this cycle: take the new code, else the held one
					dac_code[ch] <= write_mask[ch] ? new_code : input_code[ch];
				end
			end
		end
	end

	// power-down flags; clear does not power channels down or up
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_down_q <= '0;
		end else if (enable) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (update_mask[ch]) begin
					power_down_q[ch] <= 1'b0;
				end else if (down_mask[ch]) begin
					power_down_q[ch] <= 1'b1;
				end
			end
		end
	end

	// settling timers start when a sleeping channel is woken
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt_q <= '0;
		end else if (enable) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (update_mask[ch] && power_down_q[ch]) begin
					if (&power_down_q) begin
						// bias was off too; 3 V supply takes longest
						settle_cnt_q[ch] <= low_supply_sync ?
							PU_BIAS_LO_CYC : PU_BIAS_HI_CYC;
					end else begin
						settle_cnt_q[ch] <= PU_SHORT_CYC;
					end
				end else if (power_down_q[ch]) begin
					// a sleeping channel has nothing to settle
					settle_cnt_q[ch] <= '0;
				end else if (settle_cnt_q[ch] != '0) begin
					settle_cnt_q[ch] <= settle_cnt_q[ch] - 10'h001;
				end
			end
		end
	end

	// status outputs, all from flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			output_drive_en <= '1;
			channel_settled <= '1;
			bias_on <= 1'b1;
			command_done <= 1'b0;
		end else if (enable) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				// driver off while asleep, so the pin floats
				output_drive_en[ch] <= ~power_down_q[ch];
				channel_settled[ch] <= ~power_down_q[ch] && (settle_cnt_q[ch] == '0);
			end
			// shared bias stays on while any channel is awake
			bias_on <= ~(&power_down_q);
			command_done <= run;
		end
	end

endmodule : qdc_command_logic

`default_nettype wire

//--- qdc_command_logic_assertions.sv
/*
 * port checker for the quad converter command logic, bound below.
 * assumes the 25 MHz system clock and a host-driven serial clock.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_checker #(
	parameter int CODE_BITS = 16,
	parameter bit MIDSCALE_RESET = 1'b0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic serial_clock,
	input wire logic select_load_n,
	input wire logic serial_in,
	input wire logic async_clear_n,
	input wire logic chain_serial_out,
	input wire logic [qdc_pkg::NUM_CHANNELS-1:0][CODE_BITS-1:0] input_code,
	input wire logic [qdc_pkg::NUM_CHANNELS-1:0][CODE_BITS-1:0] dac_code,
	input wire logic [qdc_pkg::NUM_CHANNELS-1:0] output_drive_en,
	input wire logic [qdc_pkg::NUM_CHANNELS-1:0] channel_settled,
	input wire logic bias_on,
	input wire logic command_done
);
	import qdc_pkg::*;
	localparam logic [CODE_BITS-1:0] RST_CODE = CODE_BITS'(MIDSCALE_RESET) << (CODE_BITS - 1);
	logic [31:0] hist_q; // selected serial bits, newest in bit 0
	logic [9:0] low_cnt_q; // cycles channel 0 awake but unsettled
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// shadow of the shift path; cleared like the design's shift register
	always_ff @(posedge serial_clock or negedge rst_n or negedge async_clear_n) begin
		if (!rst_n || !async_clear_n) begin
			hist_q <= '0;
		end else if (!select_load_n) begin
			hist_q <= {hist_q[30:0], serial_in};
		end
	end
	// counts from wake, so time spent powered down is not included
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_q <= '0;
		end else if (channel_settled[0] || !output_drive_en[0]) begin
			low_cnt_q <= '0;
		end else begin
			low_cnt_q <= low_cnt_q + 10'h001;
		end
	end
	sequence s_wake;
		$rose(output_drive_en[0]);
	endsequence
	sequence s_unsettled;
		!channel_settled[0] [*8];
	endsequence
	a_clear_codes: assert property (!async_clear_n |-> (dac_code == {NUM_CHANNELS{RST_CODE}})
		&& (input_code == {NUM_CHANNELS{RST_CODE}})) else $error("codes not cleared");
	a_bias_tracks: assert property (bias_on == (|output_drive_en))
		else $error("bias state wrong");
	a_done_pulse: assert property (command_done |=> !command_done)
		else $error("done longer than one cycle");
	// codes and the done pulse come from the same edge
	a_code_then_done: assert property (($changed(dac_code) || $changed(input_code))
		&& async_clear_n && $past(async_clear_n) |-> command_done) else $error("code without done");
	// drive enables are one flop behind the power flags, so one cycle after done
	a_drive_then_done: assert property ($changed(output_drive_en) |-> $past(command_done))
		else $error("power state without done");
	a_down_unsettled: assert property ((channel_settled & ~output_drive_en) == 4'h0)
		else $error("powered-down channel settled");
	a_wake_delay: assert property (s_wake |-> s_unsettled)
		else $error("wake without delay");
	a_settle_count: assert property ($rose(channel_settled[0]) |-> low_cnt_q inside
		{[124:126], [299:301], [749:751]}) else $error("power-up delay length wrong");
	// sampled on the rising edge: the falling edge before it has moved the top bit out
	a_chain_delay: assert property (@(posedge serial_clock) disable iff (!rst_n)
		chain_serial_out == hist_q[31]) else $error("chain output not delayed 32 edges");
endmodule : qdc_checker

bind qdc_command_logic qdc_checker #(.CODE_BITS(CODE_BITS), .MIDSCALE_RESET(MIDSCALE_RESET))
	u_qdc_checker (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock),
	.select_load_n(select_load_n), .serial_in(serial_in), .async_clear_n(async_clear_n),
	.chain_serial_out(chain_serial_out), .input_code(input_code), .dac_code(dac_code),
	.output_drive_en(output_drive_en), .channel_settled(channel_settled),
	.bias_on(bias_on), .command_done(command_done));

`default_nettype wire

//--- qdc_host_model.sv
/*
 * host serial controller model: select, 12 ns serial clock, data.
 * assumes the device samples data on the rising serial edge.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_host_model (
	output var logic serial_clock,
	output var logic select_load_n,
	output var logic serial_in
);
	// idle: deselected, serial clock parked
	initial begin
		serial_clock = 1'b0;
		select_load_n = 1'b1;
		serial_in = 1'b0;
	end
	// one frame msb first; slow stretches the wait before select and the end of frame
	task automatic send_frame(input logic [31:0] word, input int nbits, input int slow);
		int i;
		#(3 + slow) select_load_n = 1'b0;
		#7;
		for (i = nbits - 1; i >= 0; i--) begin
			serial_in = word[i];
			#6 serial_clock = 1'b1;
			#6 serial_clock = 1'b0;
		end
		#(4 + slow) select_load_n = 1'b1;
		serial_in = ~serial_in; // released line shows no stale bit
	endtask : send_frame
endmodule : qdc_host_model

`default_nettype wire

//--- qdc_command_logic_tb.sv
/*
 * self-checking bench for the quad converter command logic.
 * assumes the host model drives the link; bench drives the rest.
 */
`timescale 1ns/10ps
`default_nettype none

module qdc_command_logic_tb;
	import qdc_pkg::*;
	logic clock, rst_n, enable, async_clear_n, low_supply;
	logic serial_clock, select_load_n, serial_in, chain_serial_out, bias_on, command_done;
	logic [NUM_CHANNELS-1:0][15:0] input_code, dac_code;
	logic [NUM_CHANNELS-1:0] output_drive_en, channel_settled;
	logic [15:0] exp_in [4]; // expected input registers
	logic [15:0] exp_dac [4]; // expected active codes
	logic [3:0] exp_pd; // expected powered-down channels
	logic [3:0] cmds [7] = '{CMD_WRITE, CMD_UPDATE, CMD_WRITE_UPD, CMD_WRITE_UPD_ALL,
		CMD_POWER_DOWN, CMD_NOP, 4'h5};
	logic [3:0] addrs [5] = '{ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3, ADDR_ALL};
	int num_errors, checked;
	// 25 MHz system clock
	initial clock = 1'b0;
	always #20 clock = ~clock;
	qdc_command_logic #(.CODE_BITS(16), .MIDSCALE_RESET(1'b0)) u_qdc_command_logic (
		.clock(clock), .rst_n(rst_n), .enable(enable), .serial_clock(serial_clock),
		.select_load_n(select_load_n), .serial_in(serial_in), .async_clear_n(async_clear_n),
		.low_supply(low_supply), .chain_serial_out(chain_serial_out),
		.input_code(input_code), .dac_code(dac_code), .output_drive_en(output_drive_en),
		.channel_settled(channel_settled), .bias_on(bias_on), .command_done(command_done));
	qdc_host_model u_qdc_host_model (.serial_clock(serial_clock),
		.select_load_n(select_load_n), .serial_in(serial_in));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	// settling time of a woken channel, in system clocks
	function automatic int pu_cycles(input logic all_down, input logic low);
		return all_down ? (low ? 750 : 300) : 125;
	endfunction : pu_cycles
	task automatic check_all();
		for (int c = 0; c < 4; c++) begin
			check(32'(input_code[c]), 32'(exp_in[c]));
			check(32'(dac_code[c]), 32'(exp_dac[c]));
		end
		check(32'(output_drive_en), {28'h0000000, ~exp_pd});
		check(32'(bias_on), 32'(exp_pd != 4'hF));
	endtask : check_all
	// one frame, then the reference model and the comparisons
	task automatic frame(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data,
		input int nbits);
		logic [3:0] sel;
		logic [3:0] wake;
		logic all_down;
		int n;
		int ch;
		logic [31:0] word;
		repeat (2) @(posedge clock);
		word = {8'($urandom()), cmd, addr, data};
		u_qdc_host_model.send_frame(word, nbits, $urandom_range(0, 20));
		// after a full-width frame the first bit sent sits at the chain output
		if (nbits == 32) check(32'(chain_serial_out), 32'(word[31]));
		n = 0;
		// sample on the falling edge, where the outputs have settled
		while (command_done !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		// drive enables trail the done pulse by one cycle
		@(negedge clock);
		if (nbits < 24) begin
			check(32'(n), 32'h14);
		end else if (n == 20) begin
			num_errors++;
			test_done();
		end else begin
			sel = (addr == ADDR_ALL) ? 4'hF : ((addr < 4'h4) ? 4'h1 << addr[1:0] : 4'h0);
			wake = 4'h0;
			all_down = (exp_pd == 4'hF);
			for (int c = 0; c < 4; c++) begin
				if (sel[c] && cmd inside {CMD_WRITE, CMD_WRITE_UPD_ALL, CMD_WRITE_UPD}) exp_in[c] = data;
				if ((sel[c] && cmd inside {CMD_UPDATE, CMD_WRITE_UPD}) || cmd == CMD_WRITE_UPD_ALL) begin
					exp_dac[c] = exp_in[c];
					wake[c] = exp_pd[c];
					exp_pd[c] = 1'b0;
				end
				if (sel[c] && cmd == CMD_POWER_DOWN) exp_pd[c] = 1'b1;
			end
			check_all();
			if (wake != 4'h0) begin
				ch = wake[0] ? 0 : (wake[1] ? 1 : (wake[2] ? 2 : 3));
				n = 0;
				while (channel_settled[ch] !== 1'b1 && n < 1000) begin
					@(negedge clock);
					n++;
				end
				// a channel that never settles ends the run
				if (n == 1000) begin
					num_errors++;
					test_done();
				end
				check(32'(n > pu_cycles(all_down, low_supply) - 4), 32'h1);
				check(32'(n < pu_cycles(all_down, low_supply) + 2), 32'h1);
			end
		end
	endtask : frame
	// main sequence
	initial begin
		rst_n = 1'b0;
		enable = 1'b1;
		async_clear_n = 1'b1;
		low_supply = 1'b0;
		num_errors = 0;
		checked = 0;
		exp_pd = 4'h0;
		for (int c = 0; c < 4; c++) begin
			exp_in[c] = 16'h0000;
			exp_dac[c] = 16'h0000;
		end
		void'($urandom(10));
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		check_all();
		check(32'(channel_settled), 32'hF);
		// every command on every channel code, all channels end powered down
		foreach (cmds[i]) begin
			foreach (addrs[j]) begin
				frame(cmds[i], addrs[j], 16'($urandom()), 24);
			end
		end
		frame(CMD_UPDATE, ADDR_CH2, 16'h0000, 24); // bias was off
		frame(CMD_POWER_DOWN, ADDR_CH2, 16'hFFFF, 32);
		low_supply <= 1'b1;
		frame(CMD_WRITE_UPD, ADDR_CH2, 16'hFFFF, 32); // long delay at low supply
		frame(CMD_WRITE_UPD, ADDR_CH0, 16'h8001, 24); // bias stays on
		frame(CMD_WRITE_UPD, 4'h7, 16'h1234, 24); // reserved channel code
		frame(CMD_WRITE, ADDR_CH1, 16'h5A5A, 20); // short frame dropped
		check_all();
		for (int k = 0; k < 40; k++) begin
			frame(cmds[$urandom_range(0, 6)], addrs[$urandom_range(0, 4)], 16'($urandom()),
				$urandom_range(0, 1) ? 32 : 24);
		end
		async_clear_n <= 1'b0;
		repeat (2) @(posedge clock);
		async_clear_n <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			exp_in[c] = 16'h0000;
			exp_dac[c] = 16'h0000;
		end
		@(posedge clock);
		check_all();
		check(32'(chain_serial_out), 32'h0);
		frame(CMD_WRITE_UPD_ALL, ADDR_CH3, 16'hC3C3, 32);
		test_done();
	end
endmodule : qdc_command_logic_tb

`default_nettype wire
